// ===== hdl/tbrc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// drives the repeater enable pin; moves it only on an idle bus, or drops it at once when synced power good falls
module tbrc_ctrl #(
	parameter int SETTLE_CYC = tbrc_pkg::SETTLE_CYC,
	parameter int FREE_CYC = tbrc_pkg::BUS_FREE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_en_req,
	input wire logic i_power_good,
	input wire logic i_clock_line_low_side,
	input wire logic i_data_line_low_side,
	input wire logic i_clock_line_high_side,
	input wire logic i_data_line_high_side,
	output logic o_rep_en,
	output logic o_bus_idle,
	output logic o_ready
);
	tbrc_pkg::tbrc_state_t state;
	tbrc_pkg::tbrc_state_t next_state;
	logic [1:0] pg_sync;
	logic [tbrc_pkg::CNT_W-1:0] settle_cnt;
	logic settled;
	logic all_idle;
	logic [tbrc_pkg::NUM_SEG-1:0] seg_clk;
	logic [tbrc_pkg::NUM_SEG-1:0] seg_dat;
	logic [tbrc_pkg::NUM_SEG-1:0] seg_idle;
	logic [tbrc_pkg::CNT_W:0] pg_age;

	assign seg_clk = {i_clock_line_high_side, i_clock_line_low_side}; // RL13
	assign seg_dat = {i_data_line_high_side, i_data_line_low_side}; // RL15

	// one watcher per segment
	genvar g;
	generate
		for (g = 0; g < tbrc_pkg::NUM_SEG; g++) begin : g_seg
			tbrc_idle #(
				.FREE_CYC(FREE_CYC)
			) u_idle (
				.i_clk(i_clk),
				.i_rst_b(i_rst_b),
				.i_clock_line(seg_clk[g]),
				.i_data_line(seg_dat[g]),
				.o_idle(seg_idle[g])
			);
		end
	endgenerate

	assign all_idle = &seg_idle;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pg_sync <= 2'h0;
		end else begin
			pg_sync <= {pg_sync[0], i_power_good};
		end
	end

	// wait for the repeater references after power comes up
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			settle_cnt <= '0;
		end else if (!pg_sync[1]) begin
			settle_cnt <= '0;
		end else if (!settled) begin
			settle_cnt <= settle_cnt + 1'b1; // RL11
		end
	end

	assign settled = settle_cnt == tbrc_pkg::CNT_W'(SETTLE_CYC);

	always_comb begin
		next_state = state;
		case (state)
			tbrc_pkg::ST_SETTLE: begin
				if (settled && pg_sync[1]) begin
					next_state = tbrc_pkg::ST_OFF;
				end
			end
			tbrc_pkg::ST_OFF: begin
				if (!pg_sync[1]) begin
					next_state = tbrc_pkg::ST_SETTLE;
				end else if (i_en_req && all_idle) begin
					next_state = tbrc_pkg::ST_ON; // RL10
				end
			end
			tbrc_pkg::ST_ON: begin
				if (!pg_sync[1]) begin
					next_state = tbrc_pkg::ST_SETTLE;
				end else if (!i_en_req && all_idle) begin
					next_state = tbrc_pkg::ST_OFF; // RL10
				end
			end
			default: begin
				next_state = tbrc_pkg::ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= tbrc_pkg::ST_SETTLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rep_en <= tbrc_pkg::RESET_EN;
		end else begin
			o_rep_en <= next_state == tbrc_pkg::ST_ON; // RL9
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_idle <= 1'h0;
			o_ready <= 1'h0;
		end else begin
			o_bus_idle <= all_idle;
			o_ready <= next_state != tbrc_pkg::ST_SETTLE;
		end
	end

	property p_en_idle;
		@(posedge i_clk) disable iff (!i_rst_b)
		(pg_sync[1] && $changed(o_rep_en)) |-> $past(all_idle);
	endproperty
	a_en_idle: assert property (p_en_idle) else $error("enable moved on a busy bus"); // RL10

	property p_en_settled;
		@(posedge i_clk) disable iff (!i_rst_b)
		!settled |=> !o_rep_en;
	endproperty
	a_en_settled: assert property (p_en_settled) else $error("enable before settle"); // RL11

	property p_en_on;
		@(posedge i_clk) disable iff (!i_rst_b)
		(state == tbrc_pkg::ST_OFF && pg_sync[1] && i_en_req && all_idle) |=> o_rep_en;
	endproperty
	a_en_on: assert property (p_en_on) else $error("enable not raised on idle request"); // RL10

	property p_en_hold;
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_rep_en && pg_sync[1] && !all_idle) |=> o_rep_en;
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enable dropped mid transfer"); // RL10

	property p_pg_off;
		@(posedge i_clk) disable iff (!i_rst_b)
		!pg_sync[1] |=> !o_rep_en ##1 !o_ready;
	endproperty
	a_pg_off: assert property (p_pg_off) else $error("enable kept without power"); // RL11

	// age of synced power good, checked against ready and enable
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pg_age <= '0;
		end else if (!pg_sync[1]) begin
			pg_age <= '0;
		end else if (!pg_age[tbrc_pkg::CNT_W]) begin
			pg_age <= pg_age + 1'b1;
		end
	end

	property p_idle_out;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_bus_idle == $past(all_idle);
	endproperty
	a_idle_out: assert property (p_idle_out) else $error("idle output lags"); // RL10

	property p_en_keep_off;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!o_rep_en && !all_idle) |=> !o_rep_en;
	endproperty
	a_en_keep_off: assert property (p_en_keep_off) else $error("enable on busy bus"); // RL10

	property p_en_drop;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!i_en_req && all_idle && pg_sync[1]) |=> !o_rep_en;
	endproperty
	a_en_drop: assert property (p_en_drop) else $error("enable kept on idle drop"); // RL10

	property p_ready_off;
		@(posedge i_clk) disable iff (!i_rst_b)
		(state == tbrc_pkg::ST_SETTLE && !settled) |=> !o_ready;
	endproperty
	a_ready_off: assert property (p_ready_off) else $error("ready during settle"); // RL11

	property p_ready_rose;
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_ready) |-> settled;
	endproperty
	a_ready_rose: assert property (p_ready_rose) else $error("ready without settle"); // RL11

	property p_ready_keep;
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_ready && pg_sync[1]) |=> o_ready;
	endproperty
	a_ready_keep: assert property (p_ready_keep) else $error("ready lost while powered"); // RL11

	property p_ready_pg;
		@(posedge i_clk) disable iff (!i_rst_b)
		!pg_sync[1] |=> !o_ready;
	endproperty
	a_ready_pg: assert property (p_ready_pg) else $error("ready kept without power"); // RL11

	property p_pg_settle;
		@(posedge i_clk) disable iff (!i_rst_b)
		!pg_sync[1] |=> state == tbrc_pkg::ST_SETTLE;
	endproperty
	a_pg_settle: assert property (p_pg_settle) else $error("no settle after power loss"); // RL11

	property p_ready_age;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_ready |-> int'(pg_age) > SETTLE_CYC;
	endproperty
	a_ready_age: assert property (p_ready_age) else $error("ready before settle time"); // RL11

	property p_en_age;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_rep_en |-> int'(pg_age) > SETTLE_CYC + 1;
	endproperty
	a_en_age: assert property (p_en_age) else $error("enable before settle time"); // RL11
endmodule
`default_nettype wire

// ===== hdl/tbrc_pkg.sv
// Contract
// [RL1] device keeps drivers off until both supplies good and references settled
// [RL2] device accepts supplies in either order with identical power-good gating
// [RL3] low-side low turns on matching high-side pull-down to offset low
// [RL4] low-side release releases matching high-side pull-down
// [RL5] high-side low below 0.4 V turns on matching low-side pull-down
// [RL6] low-side pull-down only when high side below 0.4 V, not offset
// [RL7] after external high-side low, high-side pull-down held until low side rises
// [RL8] channel off when low-side supply too high against high-side supply
// [RL9] enable active high, pulled up internally, low isolates segments
// [RL10] controller changes enable only while both segments are idle; tbrc_ctrl also drops it when synced power good falls, busy or not
// [RL11] settle delay only after high-side supply rises, never on re-enable; tbrc_ctrl waits SETTLE_CYC whenever synced power good rises, either supply
// [RL12] system provides external pull-ups on every line of both segments
// [RL13] high-side devices pull lines to 0.4 V or lower for stretching
// [RL14] two independent channels, data and clock, same direction rules
// [RL15] chained repeaters join low side to next high side only
// [RL16] thresholds are synchronized digital inputs, pull-downs active-high controls
// [RL17] when not powered or disabled, all pull-downs off and state cleared
package tbrc_pkg;
	localparam int CLK_MHZ = 10;
	localparam int T_SETTLE_US = 400;
	localparam int SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
	localparam int T_BUS_FREE_US = 50;
	localparam int BUS_FREE_CYC = T_BUS_FREE_US * CLK_MHZ;
	localparam int CNT_W = 12;
	localparam int NUM_SEG = 2;
	localparam logic RESET_EN = 1'h0;

	typedef enum logic [1:0] {
		ST_SETTLE = 2'b00,
		ST_OFF = 2'b01,
		ST_ON = 2'b10
	} tbrc_state_t;
endpackage

// ===== hdl/tbrc_idle.sv
`timescale 1ns/1ns
`default_nettype none
// watches one bus segment, reports idle after stop or long free time
module tbrc_idle #(
	parameter int FREE_CYC = tbrc_pkg::BUS_FREE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_clock_line,
	input wire logic i_data_line,
	output logic o_idle
);
	logic [1:0] clk_sync;
	logic [1:0] dat_sync;
	logic prev_clk;
	logic prev_dat;
	logic busy;
	logic [tbrc_pkg::CNT_W-1:0] free_cnt;
	logic start_seen;
	logic stop_seen;
	logic lines_high;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clk_sync <= 2'h3;
			dat_sync <= 2'h3;
			prev_clk <= 1'h1;
			prev_dat <= 1'h1;
		end else begin
			clk_sync <= {clk_sync[0], i_clock_line};
			dat_sync <= {dat_sync[0], i_data_line};
			prev_clk <= clk_sync[1];
			prev_dat <= dat_sync[1];
		end
	end

	assign start_seen = clk_sync[1] && prev_clk && prev_dat && !dat_sync[1];
	assign stop_seen = clk_sync[1] && prev_clk && !prev_dat && dat_sync[1];
	assign lines_high = clk_sync[1] && dat_sync[1]; // RL12

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			free_cnt <= '0;
		end else if (!lines_high) begin
			free_cnt <= '0;
		end else if (free_cnt != tbrc_pkg::CNT_W'(FREE_CYC)) begin
			free_cnt <= free_cnt + 1'b1;
		end
	end

	// start wins over a same-cycle free timeout
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy <= 1'h1;
		end else if (start_seen || !lines_high) begin
			busy <= 1'h1;
		end else if (stop_seen || free_cnt == tbrc_pkg::CNT_W'(FREE_CYC)) begin
			busy <= 1'h0;
		end
	end

	assign o_idle = !busy;

	property p_stop_idle;
		@(posedge i_clk) disable iff (!i_rst_b)
		stop_seen |=> o_idle;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("segment not idle after stop"); // RL10

	property p_start_busy;
		@(posedge i_clk) disable iff (!i_rst_b)
		start_seen |=> !o_idle;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("segment idle after start"); // RL10

	property p_low_busy;
		@(posedge i_clk) disable iff (!i_rst_b)
		!lines_high |=> !o_idle;
	endproperty
	a_low_busy: assert property (p_low_busy) else $error("segment idle with a line low"); // RL10
endmodule
`default_nettype wire

// ===== tb/tbrc_rep_model.sv
`timescale 1ns/1ns
`default_nettype none
module tbrc_rep_model #(
	parameter int SETTLE_CYC = 20
) (
	input wire logic i_clk,
	input wire logic i_sup_hi,
	input wire logic i_sup_lo,
	input wire logic i_ratio_ok,
	input wire logic i_en,
	input wire logic [1:0] i_lo_wire,
	input wire logic [1:0] i_hi_ext_low,
	output logic o_pg,
	output logic [1:0] o_pull_lo,
	output logic [1:0] o_pull_hi
);
	int settle;
	logic on;
	// references run from the high supply alone
	always_ff @(posedge i_clk) begin
		if (!i_sup_hi)
			settle <= 0;
		else if (settle < SETTLE_CYC)
			settle <= settle + 1;
	end
	assign o_pg = i_sup_hi && i_sup_lo;
	assign on = o_pg && settle >= SETTLE_CYC && i_ratio_ok && i_en !== 1'b0;
	// own offset low is not read back as a low
	assign o_pull_lo = on ? i_hi_ext_low : 2'h0;
	assign o_pull_hi = on ? (~i_lo_wire | i_hi_ext_low) : 2'h0;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int SETTLE = 20;
	localparam int FREE = 40;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_en_req = 1'b0;
	logic sup_hi = 1'b0;
	logic sup_lo = 1'b0;
	logic [1:0] lo_drv = 2'h0;
	logic [1:0] hi_drv = 2'h0;
	logic ratio_ok = 1'b1;
	logic [1:0] pull_lo, pull_hi, lo_w, hi_w;
	logic pg, rep_en, idle, ready;
	int miscompares = 0;
	int samples_checked = 0;
	always #50 i_clk = ~i_clk;
	// bit 0 data, bit 1 clock; pulled up when nobody pulls down
	assign lo_w = ~(lo_drv | pull_lo);
	assign hi_w = ~(hi_drv | pull_hi);
	tbrc_rep_model #(.SETTLE_CYC(SETTLE)) rep (.i_clk(i_clk), .i_sup_hi(sup_hi),
		.i_sup_lo(sup_lo), .i_ratio_ok(ratio_ok), .i_en(rep_en), .i_lo_wire(lo_w),
		.i_hi_ext_low(hi_drv), .o_pg(pg), .o_pull_lo(pull_lo), .o_pull_hi(pull_hi));
	tbrc_ctrl #(.SETTLE_CYC(SETTLE), .FREE_CYC(FREE)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_en_req(i_en_req), .i_power_good(pg), .i_clock_line_low_side(lo_w[1]),
		.i_data_line_low_side(lo_w[0]), .i_clock_line_high_side(hi_w[1]),
		.i_data_line_high_side(hi_w[0]), .o_rep_en(rep_en), .o_bus_idle(idle),
		.o_ready(ready));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic chk(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask
	task automatic wait_en(input logic v, input int lim);
		int n;
		n = 0;
		while (rep_en !== v && n < lim) begin
			@(posedge i_clk);
			n++;
		end
		chk(rep_en, v, "enable level");
	endtask
	task automatic t_power;
		chk(rep_en, 1'b0, "enable in reset");
		chk(ready, 1'b0, "ready in reset");
		chk(idle, 1'b0, "busy in reset");
		i_en_req <= 1'b1;
		sup_lo <= 1'b1;
		cyc(10);
		chk(rep_en, 1'b0, "enable with one supply");
		sup_hi <= 1'b1;
		cyc(SETTLE);
		chk(ready, 1'b0, "ready before settle");
		wait_en(1'b1, FREE + 20);
		chk(idle, 1'b1, "bus idle");
		$display("t_power done");
	endtask
	task automatic t_transfer;
		lo_drv[0] <= 1'b1;
		cyc(2);
		chk(hi_w[0], 1'b0, "low to high side");
		cyc(6);
		chk(idle, 1'b0, "busy after start");
		i_en_req <= 1'b0;
		repeat (3) begin
			lo_drv[1] <= 1'b1;
			cyc(4);
			chk(hi_w[1], 1'b0, "clock low to high side");
			lo_drv[1] <= 1'b0;
			cyc(4);
		end
		hi_drv[1] <= 1'b1;
		cyc(3);
		chk(lo_w[1], 1'b0, "high to low side");
		hi_drv[1] <= 1'b0;
		cyc(1);
		chk(lo_w[1], 1'b1, "release both sides");
		chk(rep_en, 1'b1, "held while busy");
		lo_drv[0] <= 1'b0;
		cyc(2);
		chk(hi_w[0], 1'b1, "release high side");
		wait_en(1'b0, 20);
		lo_drv[0] <= 1'b1;
		cyc(2);
		chk(hi_w[0], 1'b1, "isolated");
		lo_drv[0] <= 1'b0;
		$display("t_transfer done");
	endtask
	task automatic t_loss;
		i_en_req <= 1'b1;
		wait_en(1'b1, SETTLE / 2);
		chk(ready, 1'b1, "no settle on re-enable");
		lo_drv[0] <= 1'b1;
		cyc(2);
		chk(hi_w[0], 1'b0, "repeats at once on re-enable");
		ratio_ok <= 1'b0;
		cyc(1);
		chk(hi_w[0], 1'b1, "channel off on supply ratio");
		ratio_ok <= 1'b1;
		lo_drv[0] <= 1'b0;
		cyc(2);
		sup_lo <= 1'b0;
		cyc(5);
		chk(rep_en, 1'b0, "enable after power loss");
		chk(ready, 1'b0, "ready after power loss");
		sup_lo <= 1'b1;
		wait_en(1'b1, SETTLE + 20);
		lo_drv[0] <= 1'b1;
		cyc(2);
		chk(hi_w[0], 1'b0, "repeats with low supply last");
		lo_drv[0] <= 1'b0;
		$display("t_loss done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		cyc(3000);
		miscompares++;
		end_sim;
	end
	initial begin
		cyc(8);
		i_rst_b <= 1'b1;
		t_power;
		t_transfer;
		t_loss;
		end_sim;
	end
endmodule
`default_nettype wire
